/* exec_defs.svh */
// offsets, field positions, reset values, cycle counts and opcode patterns
// assumes a 12-bit byte address on the register bus
`ifndef EXEC_DEFS_SVH
`define EXEC_DEFS_SVH
`define OFF_CTRL      12'h000
`define OFF_PC        12'h004
`define OFF_FLAGS     12'h008
`define OFF_SP        12'h00C
`define OFF_GPR_IDX   12'h010
`define OFF_GPR_DATA  12'h014
`define CTRL_RUN_BIT  0
`define CTRL_ERR_BIT  1
`define PC_RST        16'h0000
`define SP_RST        16'h1FFF
`define FLAGS_RST     8'h00
`define FLAG_C        3'h0
`define FLAG_Z        3'h1
`define FLAG_N        3'h2
`define FLAG_V        3'h3
`define FLAG_S        3'h4
`define FLAG_H        3'h5
`define FLAG_I        3'h7
`define PTR_X_LO      5'h1A
`define PTR_X_HI      5'h1B
`define PTR_Y_LO      5'h1C
`define PTR_Y_HI      5'h1D
`define CYC_CMP       3'h1
`define CYC_REG_SKIP  3'h1
`define CYC_IO_SKIP   3'h2
`define CYC_BR        3'h1
`define CYC_LOAD_DIR  3'h2
`define CYC_LOAD_PTR  3'h1
`define CYC_LOAD_DEC  3'h2
`define CYC_EXIT      3'h4
`define PAT_CMP_REGS  16'h1400
`define PAT_CMP_CARRY 16'h0400
`define PAT_SKIP_EQ   16'h1000
`define MSK_REG_REG   16'hFC00
`define PAT_CMP_IMM   16'h3000
`define MSK_CMP_IMM   16'hF000
`define PAT_SKIP_RBIT 16'hFC00
`define MSK_SKIP_RBIT 16'hFC08
`define PAT_SKIP_IO   16'h9900
`define MSK_SKIP_IO   16'hFD00
`define PAT_BRANCH    16'hF000
`define MSK_BRANCH    16'hF800
`define PAT_LOAD_DIR  16'h9000
`define PAT_LOAD_XINC 16'h900D
`define PAT_LOAD_X    16'h900C
`define PAT_LOAD_XDEC 16'h900E
`define PAT_LOAD_YINC 16'h9009
`define PAT_LOAD_Y    16'h8008
`define MSK_LOAD      16'hFE0F
`define PAT_EXIT      16'h9508
`define MSK_EXIT      16'hFFEF
`define PAT_TWO_WORD  16'h9000
`define MSK_TWO_WORD  16'hFC0F
`define PAT_LONG_JUMP 16'h940C
`define MSK_LONG_JUMP 16'hFE0C
`endif

/* exec_pkg.sv */
// types shared by the execution unit and its decoder
// assumes exec_defs.svh supplies the numeric constants
package exec_pkg;
    typedef enum logic [1:0] {
        st_idle  = 2'b00,
        st_fetch = 2'b01,
        st_exec  = 2'b11,
        st_halt  = 2'b10
    } state_t;

    typedef enum logic [3:0] {
        op_none, op_compare_regs, op_compare_carry, op_compare_imm,
        op_skip_equal, op_skip_reg_bit, op_skip_io_bit, op_branch_flag,
        op_load_direct, op_load_ptr, op_load_ptr_dec, op_exit
    } op_t;

    typedef struct packed {
        op_t        op;
        logic [4:0] rd;
        logic [4:0] rr;
        logic [7:0] imm;
        logic [2:0] bitn;
        logic [4:0] io_addr;
        logic [6:0] koff;
        logic       want;
        logic       use_y;
    } dec_t;
endpackage

/* op_decode.sv */
// instruction decoder: a word and the word after it in, decoded fields out
// assumes words come straight from program memory, no predecode
`timescale 1ns/1ps
`include "exec_defs.svh"
module op_decode (
    // words
    input  wire logic [15:0]    word,
    input  wire logic [15:0]    next_word,
    // decoded
    output exec_pkg::dec_t      dec,
    output logic                next_two_word
);
    function automatic logic hit(input logic [15:0] w, input logic [15:0] p,
                                 input logic [15:0] m);
        hit = ((w & m) == p);
    endfunction

    always_comb begin
        dec         = '0;
        dec.op      = exec_pkg::op_none;
        dec.rd      = word[8:4];
        dec.rr      = {word[9], word[3:0]};
        dec.imm     = {word[11:8], word[3:0]};
        dec.bitn    = word[2:0];
        dec.io_addr = word[7:3];
        dec.koff    = word[9:3];
        dec.want    = ~word[10];
        if (hit(word, `PAT_CMP_REGS, `MSK_REG_REG))
            dec.op = exec_pkg::op_compare_regs;
        else if (hit(word, `PAT_CMP_CARRY, `MSK_REG_REG))
            dec.op = exec_pkg::op_compare_carry;
        else if (hit(word, `PAT_SKIP_EQ, `MSK_REG_REG))
            dec.op = exec_pkg::op_skip_equal;
        else if (hit(word, `PAT_CMP_IMM, `MSK_CMP_IMM)) begin
            dec.op = exec_pkg::op_compare_imm;
            dec.rd = {1'b1, word[7:4]};
        end else if (hit(word, `PAT_SKIP_RBIT, `MSK_SKIP_RBIT)) begin
            dec.op   = exec_pkg::op_skip_reg_bit;
            dec.want = word[9];
        end else if (hit(word, `PAT_SKIP_IO, `MSK_SKIP_IO)) begin
            dec.op   = exec_pkg::op_skip_io_bit;
            dec.want = word[9];
        end else if (hit(word, `PAT_BRANCH, `MSK_BRANCH))
            dec.op = exec_pkg::op_branch_flag;
        else if (hit(word, `PAT_LOAD_DIR, `MSK_LOAD))
            dec.op = exec_pkg::op_load_direct;
        else if (hit(word, `PAT_LOAD_XINC, `MSK_LOAD) || hit(word, `PAT_LOAD_X, `MSK_LOAD)) begin
            dec.op   = exec_pkg::op_load_ptr;
            dec.want = word[0];
        end else if (hit(word, `PAT_LOAD_YINC, `MSK_LOAD) || hit(word, `PAT_LOAD_Y, `MSK_LOAD)) begin
            dec.op    = exec_pkg::op_load_ptr;
            dec.want  = word[0];
            dec.use_y = 1'b1;
        end else if (hit(word, `PAT_LOAD_XDEC, `MSK_LOAD))
            dec.op = exec_pkg::op_load_ptr_dec;
        else if (hit(word, `PAT_EXIT, `MSK_EXIT)) begin
            dec.op   = exec_pkg::op_exit;
            dec.want = word[4];
        end
    end

    // the skipped word may be the first half of a long instruction
    assign next_two_word = hit(next_word, `PAT_TWO_WORD, `MSK_TWO_WORD)
                         | hit(next_word, `PAT_LONG_JUMP, `MSK_LONG_JUMP);
endmodule

/* compare_flags.sv */
// flag unit for the compare group: a - b - carry_in, result discarded
// assumes the caller picks operands and decides when flags are written
`timescale 1ns/1ps
`include "exec_defs.svh"
module compare_flags (
    // operands
    input  wire logic [7:0] a,
    input  wire logic [7:0] b,
    input  wire logic       carry_in,
    input  wire logic       chain_zero,
    // flags
    input  wire logic [7:0] flags_in,
    output logic [7:0]      flags_out
);
    logic [7:0] res;
    logic       v;
    logic       n;

    always_comb begin
        res = a - b - {7'h00, carry_in};
        n   = res[7];
        v   = (a[7] & ~b[7] & ~res[7]) | (~a[7] & b[7] & res[7]);
        flags_out            = flags_in;
        flags_out[`FLAG_C]   = (~a[7] & b[7]) | (b[7] & res[7]) | (res[7] & ~a[7]);
        flags_out[`FLAG_H]   = (~a[3] & b[3]) | (b[3] & res[3]) | (res[3] & ~a[3]);
        flags_out[`FLAG_N]   = n;
        flags_out[`FLAG_V]   = v;
        flags_out[`FLAG_S]   = n ^ v;
        // a carry-chained compare can only keep zero, never create it
        flags_out[`FLAG_Z]   = (res == 8'h00) & (~chain_zero | flags_in[`FLAG_Z]);
    end
endmodule

/* branch_skip_load_execution.sv */
// execution unit for compares, skips, flag branches, returns and loads
// assumes single-cycle program and data memories that answer the
// registered address combinationally in the same cycle
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "exec_defs.svh"
module branch_skip_load_execution (
    // apb slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // program memory
    output logic [15:0]      pm_addr,
    input  wire logic [15:0] pm_rdata,
    // data space and io
    output logic [15:0]      ds_addr,
    output logic             ds_re,
    input  wire logic [7:0]  ds_rdata
);
    exec_pkg::state_t st_q;
    exec_pkg::dec_t   dec_w;
    logic [2:0]  cnt_q, need_q, need_d;
    logic [15:0] ir_q, pc_q, sp_q, pm_addr_q, ds_addr_q;
    logic [15:0] word_w, ptr_w, pc_d, sp_d, ptr_d, ds_addr_d;
    logic [7:0]  status_flags_q, status_flags_d, hi_q, opa_w, opb_w, cmp_w;
    logic [7:0]  gpr_q [32];
    logic [4:0]  idx_q;
    logic [31:0] prdata_q;
    logic        ds_re_q, ds_re_d, run_q, err_q, pready_q, pslverr_q;
    logic        next_two_w, skip_w, rd_we_w, ptr_we_w, last_w;
    logic        setup_w, wr_w, idle_w, first_w;

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == `OFF_CTRL) || (a == `OFF_PC) || (a == `OFF_FLAGS) ||
                 (a == `OFF_SP) || (a == `OFF_GPR_IDX) || (a == `OFF_GPR_DATA);
    endfunction

    function automatic logic wr_at(input logic [11:0] a);
        wr_at = wr_w && (paddr == a);
    endfunction

    assign word_w = (st_q == exec_pkg::st_fetch) ? pm_rdata : ir_q;
    op_decode u_dec (
        .word          (word_w),
        .next_word     (pm_rdata),
        .dec           (dec_w),
        .next_two_word (next_two_w)
    );

    assign opa_w = gpr_q[dec_w.rd];
    assign opb_w = (dec_w.op == exec_pkg::op_compare_imm) ? dec_w.imm : gpr_q[dec_w.rr];
    assign ptr_w = dec_w.use_y ? {gpr_q[`PTR_Y_HI], gpr_q[`PTR_Y_LO]}
                               : {gpr_q[`PTR_X_HI], gpr_q[`PTR_X_LO]};
    compare_flags u_cmp (
        .a          (opa_w),
        .b          (opb_w),
        .carry_in   ((dec_w.op == exec_pkg::op_compare_carry) & status_flags_q[`FLAG_C]),
        .chain_zero (dec_w.op == exec_pkg::op_compare_carry),
        .flags_in   (status_flags_q),
        .flags_out  (cmp_w)
    );

    assign setup_w = psel & ~penable;
    assign wr_w    = psel & penable & pready_q & pwrite;
    assign idle_w  = (st_q == exec_pkg::st_idle);
    assign first_w = (st_q == exec_pkg::st_exec) && (cnt_q == 3'h0);

    always_comb begin
        pc_d = pc_q;
        sp_d = sp_q;
        status_flags_d = status_flags_q;
        need_d = need_q;
        skip_w = 1'b0;
        rd_we_w = 1'b0;
        ptr_we_w = 1'b0;
        ptr_d = ptr_w;
        ds_re_d = 1'b0;
        ds_addr_d = ds_addr_q;
        if (st_q == exec_pkg::st_fetch) begin
            case (dec_w.op)
                exec_pkg::op_load_ptr: begin
                    ds_addr_d = ptr_w;
                    ds_re_d = 1'b1;
                end
                exec_pkg::op_skip_io_bit: begin
                    ds_addr_d = {11'h000, dec_w.io_addr};
                    ds_re_d = 1'b1;
                end
                default: ;
            endcase
        end else if (first_w) begin
            case (dec_w.op)
                exec_pkg::op_compare_regs, exec_pkg::op_compare_carry,
                exec_pkg::op_compare_imm: begin
                    status_flags_d = cmp_w;
                    need_d = `CYC_CMP;
                end
                exec_pkg::op_skip_equal: begin
                    skip_w = (opa_w == opb_w);
                    need_d = `CYC_REG_SKIP;
                end
                exec_pkg::op_skip_reg_bit: begin
                    skip_w = (opa_w[dec_w.bitn] == dec_w.want);
                    need_d = `CYC_REG_SKIP;
                end
                exec_pkg::op_skip_io_bit: begin
                    skip_w = (ds_rdata[dec_w.bitn] == dec_w.want);
                    need_d = `CYC_IO_SKIP;
                end
                exec_pkg::op_branch_flag: begin
                    // every named branch is this one with a fixed flag index;
                    // the signed pair tests S, which compares keep as N xor V
                    need_d = `CYC_BR;
                    if (status_flags_q[dec_w.bitn] == dec_w.want) begin
                        pc_d = pc_q + {{9{dec_w.koff[6]}}, dec_w.koff};
                        need_d = `CYC_BR + 3'h1;
                    end
                end
                exec_pkg::op_load_direct: begin
                    ds_addr_d = pm_rdata;
                    ds_re_d = 1'b1;
                    pc_d = pc_q + 16'h0001;
                    need_d = `CYC_LOAD_DIR;
                end
                exec_pkg::op_load_ptr: begin
                    rd_we_w = 1'b1;
                    ptr_we_w = dec_w.want;
                    ptr_d = ptr_w + 16'h0001;
                    need_d = `CYC_LOAD_PTR;
                end
                exec_pkg::op_load_ptr_dec: begin
                    ptr_we_w = 1'b1;
                    ptr_d = ptr_w - 16'h0001;
                    ds_addr_d = ptr_w - 16'h0001;
                    ds_re_d = 1'b1;
                    need_d = `CYC_LOAD_DEC;
                end
                exec_pkg::op_exit: begin
                    ds_addr_d = sp_q + 16'h0001;
                    ds_re_d = 1'b1;
                    need_d = `CYC_EXIT;
                end
                default: ;
            endcase
            if (skip_w) begin
                pc_d = pc_q + (next_two_w ? 16'h0002 : 16'h0001);
                need_d = need_d + (next_two_w ? 3'h2 : 3'h1);
            end
        end else if (st_q == exec_pkg::st_exec) begin
            case (dec_w.op)
                exec_pkg::op_load_direct, exec_pkg::op_load_ptr_dec:
                    rd_we_w = (cnt_q == 3'h1);
                exec_pkg::op_exit: begin
                    if (cnt_q == 3'h1) begin
                        ds_addr_d = sp_q + 16'h0002;
                        ds_re_d = 1'b1;
                    end else if (cnt_q == 3'h2) begin
                        pc_d = {hi_q, ds_rdata};
                        sp_d = sp_q + 16'h0002;
                        if (dec_w.want)
                            status_flags_d[`FLAG_I] = 1'b1;
                    end
                end
                default: ;
            endcase
        end
    end

    assign last_w = (st_q == exec_pkg::st_exec) && (cnt_q == need_d - 3'h1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= exec_pkg::st_idle;
            cnt_q <= 3'h0;
            need_q <= 3'h0;
            ir_q <= 16'h0000;
            err_q <= 1'b0;
        end else begin
            case (st_q)
                exec_pkg::st_idle: if (run_q) st_q <= exec_pkg::st_fetch;
                exec_pkg::st_fetch: begin
                    ir_q <= pm_rdata;
                    cnt_q <= 3'h0;
                    st_q <= (dec_w.op == exec_pkg::op_none) ? exec_pkg::st_halt
                                                             : exec_pkg::st_exec;
                end
                exec_pkg::st_exec: begin
                    need_q <= need_d;
                    cnt_q <= cnt_q + 3'h1;
                    if (last_w)
                        st_q <= run_q ? exec_pkg::st_fetch : exec_pkg::st_idle;
                end
                exec_pkg::st_halt: if (!run_q) st_q <= exec_pkg::st_idle;
                default: st_q <= exec_pkg::st_idle;
            endcase
            // a fault in the same cycle as a restart stays visible
            if (st_q == exec_pkg::st_fetch && dec_w.op == exec_pkg::op_none)
                err_q <= 1'b1;
            else if (wr_at(`OFF_CTRL) && pwdata[`CTRL_RUN_BIT])
                err_q <= 1'b0;
        end
    end

    // software may only touch core state while it is stopped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_q <= `PC_RST;
            sp_q <= `SP_RST;
            status_flags_q <= `FLAGS_RST;
            hi_q <= 8'h00;
        end else if (idle_w) begin
            if (wr_at(`OFF_PC)) pc_q <= pwdata[15:0];
            if (wr_at(`OFF_SP)) sp_q <= pwdata[15:0];
            if (wr_at(`OFF_FLAGS)) status_flags_q <= pwdata[7:0];
        end else if (st_q == exec_pkg::st_fetch) begin
            pc_q <= pc_q + 16'h0001;
        end else if (st_q == exec_pkg::st_exec) begin
            pc_q <= pc_d;
            sp_q <= sp_d;
            status_flags_q <= status_flags_d;
            if (dec_w.op == exec_pkg::op_exit && cnt_q == 3'h1) hi_q <= ds_rdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pm_addr_q <= `PC_RST;
            ds_addr_q <= 16'h0000;
            ds_re_q <= 1'b0;
        end else begin
            ds_addr_q <= ds_addr_d;
            ds_re_q <= ds_re_d;
            // prefetch the following word so skips and long loads see it
            if (idle_w) pm_addr_q <= pc_q;
            else if (st_q == exec_pkg::st_fetch) pm_addr_q <= pc_q + 16'h0001;
            else if (last_w) pm_addr_q <= pc_d;
        end
    end

    // the loaded register wins over a pointer write to the same register
    always_ff @(posedge pclk) begin
        if (idle_w && wr_at(`OFF_GPR_DATA))
            gpr_q[idx_q] <= pwdata[7:0];
        if (ptr_we_w) begin
            gpr_q[dec_w.use_y ? `PTR_Y_LO : `PTR_X_LO] <= ptr_d[7:0];
            gpr_q[dec_w.use_y ? `PTR_Y_HI : `PTR_X_HI] <= ptr_d[15:8];
        end
        if (rd_we_w)
            gpr_q[dec_w.rd] <= ds_rdata;
    end

    // no wait state; read data is registered in the setup cycle so it leaves a flip-flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            run_q <= 1'b0;
            idx_q <= 5'h00;
        end else begin
            pready_q <= setup_w;
            if (setup_w) begin
                pslverr_q <= ~mapped(paddr);
                case (paddr)
                    `OFF_CTRL:     prdata_q <= {28'h0, st_q, err_q, run_q};
                    `OFF_PC:       prdata_q <= {16'h0000, pc_q};
                    `OFF_FLAGS:    prdata_q <= {24'h000000, status_flags_q};
                    `OFF_SP:       prdata_q <= {16'h0000, sp_q};
                    `OFF_GPR_IDX:  prdata_q <= {27'h0, idx_q};
                    `OFF_GPR_DATA: prdata_q <= {24'h000000, gpr_q[idx_q]};
                    default:       prdata_q <= 32'h0000_0000;
                endcase
            end
            if (wr_at(`OFF_CTRL)) run_q <= pwdata[`CTRL_RUN_BIT];
            if (wr_at(`OFF_GPR_IDX)) idx_q <= pwdata[4:0];
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign pm_addr = pm_addr_q;
    assign ds_addr = ds_addr_q;
    assign ds_re   = ds_re_q;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // a return holds the core for exactly four execute cycles, then leaves
    sequence exec_four_then_done;
        (st_q == exec_pkg::st_exec) [*4] ##0 (cnt_q == `CYC_EXIT - 3'h1)
        ##1 (st_q != exec_pkg::st_exec);
    endsequence

    compare_one_cycle_a: assert property (
        st_q == exec_pkg::st_fetch && dec_w.op inside {exec_pkg::op_compare_regs,
            exec_pkg::op_compare_imm} |=> st_q == exec_pkg::st_exec && !rd_we_w
            && !ptr_we_w ##1 st_q != exec_pkg::st_exec)
        else $error("compare took wrong time or wrote a register");
    skip_equal_pc_a: assert property (
        first_w && dec_w.op == exec_pkg::op_skip_equal && opa_w == opb_w && !next_two_w
        |=> pc_q == $past(pc_q) + 16'h0001 ##1 st_q != exec_pkg::st_exec)
        else $error("equal skip did not skip one word in two cycles");
    reg_bit_skip_a: assert property (
        first_w && dec_w.op == exec_pkg::op_skip_reg_bit
        && opa_w[dec_w.bitn] != dec_w.want |=> pc_q == $past(pc_q))
        else $error("register bit skip moved pc without cause");
    io_skip_read_a: assert property (
        st_q == exec_pkg::st_fetch && dec_w.op == exec_pkg::op_skip_io_bit
        |=> ds_re_q && ds_addr_q[15:5] == 11'h000 ##1 st_q == exec_pkg::st_exec)
        else $error("io skip did not read its io location");
    branch_taken_a: assert property (
        first_w && dec_w.op == exec_pkg::op_branch_flag && status_flags_q[dec_w.bitn] == dec_w.want
        |=> pc_q == $past(pc_q) + {{9{$past(dec_w.koff[6])}}, $past(dec_w.koff)}
        ##1 st_q != exec_pkg::st_exec)
        else $error("taken branch target or length wrong");
    branch_not_taken_a: assert property (
        first_w && dec_w.op == exec_pkg::op_branch_flag && status_flags_q[dec_w.bitn] != dec_w.want
        |=> st_q != exec_pkg::st_exec && pc_q == $past(pc_q))
        else $error("untaken branch changed pc or ran long");
    load_direct_a: assert property (
        first_w && dec_w.op == exec_pkg::op_load_direct
        |=> ds_re_q && ds_addr_q == $past(pm_rdata) && status_flags_q == $past(status_flags_q)
        ##1 st_q != exec_pkg::st_exec)
        else $error("direct load address, flags or length wrong");
    load_inc_ptr_a: assert property (
        first_w && dec_w.op == exec_pkg::op_load_ptr && dec_w.want && !dec_w.use_y
        && dec_w.rd[4:1] != 4'hD |=> {gpr_q[`PTR_X_HI], gpr_q[`PTR_X_LO]} == $past(ptr_w) + 16'h0001)
        else $error("post increment pointer wrong");
    load_dec_ptr_a: assert property (
        first_w && dec_w.op == exec_pkg::op_load_ptr_dec
        |=> ds_re_q && ds_addr_q == $past(ptr_w) - 16'h0001 ##1 status_flags_q == $past(status_flags_q, 2))
        else $error("pre decrement address or flags wrong");
    exit_four_a: assert property (
        st_q == exec_pkg::st_fetch && dec_w.op == exec_pkg::op_exit
        |=> exec_four_then_done ##0 sp_q == $past(sp_q, 5) + 16'h0002)
        else $error("return length or stack pointer wrong");
endmodule

/* mem_model.sv */
// program memory and data space beside the execution unit
// assumes answers come combinationally in the cycle the address is shown
`timescale 1ns/1ps
module mem_model (
    // clock
    input  wire logic        pclk,
    // program memory
    input  wire logic [15:0] pm_addr,
    output logic [15:0]      pm_rdata,
    // data space
    input  wire logic [15:0] ds_addr,
    input  wire logic        ds_re,
    output logic [7:0]       ds_rdata
);
    logic [15:0] pm [0:15];
    logic [7:0]  junk_q = 8'h3C;
    // unread data lines wander so a stale byte never passes for a read
    always_ff @(posedge pclk) junk_q <= junk_q + 8'h35;
    assign pm_rdata = pm[pm_addr[3:0]];
    assign ds_rdata = ds_re ? (ds_addr[7:0] ^ 8'h5A) : junk_q;
endmodule

/* testbench.sv */
// apb bench: loads a tiny program, runs the core, checks registers
// assumes mem_model answers program and data reads
`timescale 1ns/1ps
`include "exec_defs.svh"
module testbench;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, ds_re;
    logic [15:0] pm_addr, pm_rdata, ds_addr;
    logic [7:0]  ds_rdata;
    int n_errors = 0, n_checks = 0;
    always #12.5 pclk = ~pclk;
    branch_skip_load_execution u_branch_skip_load_execution (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pm_addr(pm_addr),
        .pm_rdata(pm_rdata), .ds_addr(ds_addr), .ds_re(ds_re), .ds_rdata(ds_rdata));
    mem_model u_mem_model (.pclk(pclk), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
        .ds_addr(ds_addr), .ds_re(ds_re), .ds_rdata(ds_rdata));
    task automatic test_done(input bit tmo);
        if (tmo) n_errors++;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one apb transfer; an idle cycle follows so strobes are never re-driven at once
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 16) test_done(1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic setr(input logic [4:0] r, input logic [7:0] v);
        apb(1'b1, `OFF_GPR_IDX, {27'h0, r});
        apb(1'b1, `OFF_GPR_DATA, {24'h0, v});
    endtask
    task automatic getr(input logic [4:0] r, input logic [7:0] v);
        apb(1'b1, `OFF_GPR_IDX, {27'h0, r});
        apb(1'b0, `OFF_GPR_DATA, 32'h0);
        chk("gpr", {24'h0, v}, rd);
    endtask
    // start the core and poll until it halts on a filler word
    task automatic run_to_halt();
        apb(1'b1, `OFF_CTRL, 32'h1);
        for (int i = 0; i < 40; i++) begin
            apb(1'b0, `OFF_CTRL, 32'h0);
            if (rd[3:2] === 2'b10) break;
        end
        if (rd[3:2] !== 2'b10) test_done(1'b1);
        chk("halt", 32'hB, rd);
        apb(1'b1, `OFF_CTRL, 32'h0);
    endtask
    initial begin
        for (int j = 0; j < 16; j++) u_mem_model.pm[j] = 16'hFFFF;
        u_mem_model.pm[0] = 16'h901D; // load r1 via X, post-increment
        u_mem_model.pm[1] = 16'hF011; // branch on zero set, k = 2
        u_mem_model.pm[2] = 16'h902D; // load r2 via X, only when not branched
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `OFF_SP, 32'h0);
        chk("sp", 32'h0000_1FFF, rd);
        apb(1'b0, 12'h018, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        for (int z = 0; z < 2; z++) begin
            apb(1'b1, `OFF_PC, 32'h0);
            setr(5'h1A, 8'h00);
            setr(5'h1B, 8'h01);
            setr(5'h02, 8'h77);
            apb(1'b1, `OFF_FLAGS, 32'(z * 2));
            run_to_halt();
            getr(5'h01, 8'h5A);
            getr(5'h02, z ? 8'h77 : 8'h5B);
            getr(5'h1A, z ? 8'h01 : 8'h02);
            apb(1'b0, `OFF_FLAGS, 32'h0);
            chk("flags", 32'(z * 2), rd);
        end
        // second program: compare, all three skips, direct and pre-decrement loads, return
        u_mem_model.pm[0]  = 16'h3100; // compare r16 with 0x10
        u_mem_model.pm[1]  = 16'h1301; // r16 equals r17: skip one word
        u_mem_model.pm[2]  = 16'h902D; // skipped
        u_mem_model.pm[3]  = 16'hFD04; // r16 bit 4 set: no skip
        u_mem_model.pm[4]  = 16'h9900; // io 0 bit 0 clear: skip a two-word load
        u_mem_model.pm[5]  = 16'h9020;
        u_mem_model.pm[6]  = 16'h0000;
        u_mem_model.pm[7]  = 16'h9030; // r3 from data address 0x0123
        u_mem_model.pm[8]  = 16'h0123;
        u_mem_model.pm[9]  = 16'h904E; // r4 from X after pre-decrement
        u_mem_model.pm[10] = 16'h9518; // interrupt exit pops 0x0E0F
        apb(1'b1, `OFF_PC, 32'h0);
        apb(1'b1, `OFF_SP, 32'h53);
        setr(5'h10, 8'h10);
        setr(5'h11, 8'h10);
        setr(5'h02, 8'h77);
        setr(5'h1A, 8'h00);
        setr(5'h1B, 8'h02);
        apb(1'b1, `OFF_FLAGS, 32'h0);
        run_to_halt();
        getr(5'h02, 8'h77);
        getr(5'h03, 8'h79);
        getr(5'h04, 8'hA5);
        getr(5'h1A, 8'hFF);
        apb(1'b0, `OFF_FLAGS, 32'h0);
        chk("flags", 32'h82, rd);
        apb(1'b0, `OFF_SP, 32'h0);
        chk("sp", 32'h55, rd);
        apb(1'b0, `OFF_PC, 32'h0);
        chk("pc", 32'h0E10, rd);
        test_done(1'b0);
    end
endmodule
